// [shared/cgc_pkg.sv]
// register map, reset values and timing constants of the clock generator control
package cgc_pkg;
	// register addresses on the cpu special-function bus
	localparam logic [15:0] ADDR_INTERNAL_OSC_MODE  = 16'hFFA0;
	localparam logic [15:0] ADDR_MAIN_CLOCK_SELECT  = 16'hFFA1;
	localparam logic [15:0] ADDR_HS_OSC_CONTROL     = 16'hFFA2;
	localparam logic [15:0] ADDR_CPU_DIVIDER_CONTROL = 16'hFFFB;
	localparam logic [15:0] ADDR_HS_CLOCK_MODE_SELECT = 16'hFFA5;

	// reset values
	localparam logic [7:0] RST_INTERNAL_OSC_MODE   = 8'h00;
	localparam logic [7:0] RST_MAIN_CLOCK_SELECT   = 8'h00;
	localparam logic [7:0] RST_HS_OSC_CONTROL      = 8'h80;
	localparam logic [7:0] RST_CPU_DIVIDER_CONTROL = 8'h01;
	localparam logic [7:0] RST_HS_CLOCK_MODE_SELECT = 8'h00;

	// field positions
	localparam int HI_OSC_HALT_BIT        = 0;
	localparam int LO_OSC_HALT_BIT        = 1;
	localparam int HI_OSC_STABLE_BIT      = 7;
	localparam int MAIN_SOURCE_PICK_BIT   = 0;
	localparam int MAIN_SOURCE_STATE_BIT  = 1;
	localparam int HS_SOURCE_PERMIT_BIT   = 2;
	localparam int HS_CLOCK_HALT_BIT      = 7;
	localparam int EXT_CLOCK_INPUT_SEL_BIT = 7;
	localparam int X1_PIN_FUNCTION_BIT    = 6;

	// cpu divider codes
	localparam logic [2:0] DIV_CODE_MAX = 3'h4;
	localparam int DIV_CNT_W            = 4;

	// wait for the internal oscillator accuracy to settle
	localparam int CLK_MHZ             = 25;
	localparam int HI_OSC_SETTLE_US    = 10;
	localparam int HI_OSC_SETTLE_CYC   = HI_OSC_SETTLE_US * CLK_MHZ;
	localparam int SETTLE_CNT_W        = 16;

	// gap counter load of the clock switch; the cpu enable stays low for this plus two cycles while changing source
	localparam logic [1:0] SWITCH_GAP_CYC = 2'h2;

	typedef enum logic [1:0] {
		CGC_SW_IDLE,
		CGC_SW_GAP,
		CGC_SW_DONE
	} cgc_sw_state_t;
endpackage

// [test/cgc_clock_control_checker.sv]
// port-level assertions for the clock generator control block
`timescale 1ns/1ps
`default_nettype none
module cgc_clock_control_checker
#(
	parameter int SETTLE_CYC = cgc_pkg::HI_OSC_SETTLE_CYC
)
(
	input wire logic        clk,
	input wire logic        arst_n,
	input wire logic        ce,
	input wire logic [15:0] sfr_addr,
	input wire logic        sfr_wr,
	input wire logic        sfr_rd,
	input wire logic [7:0]  sfr_wdata,
	input wire logic [7:0]  sfr_rdata,
	input wire logic        sfr_hit,
	input wire logic        stop_exec,
	input wire logic        stop_release,
	input wire logic        lo_osc_stoppable,
	input wire logic        hs_clock_ready,
	input wire logic        x1_osc_enable,
	input wire logic        ext_clock_enable,
	input wire logic        x1_pin_function,
	input wire logic        ext_clock_input_sel,
	input wire logic        hi_osc_enable,
	input wire logic        lo_osc_enable,
	input wire logic        main_src_hs,
	input wire logic        prs_src_hs,
	input wire logic        cpu_clock_en,
	input wire logic        prs_clock_en,
	input wire logic        wdt_clock_en,
	input wire logic        tmh1_lo_clock_en
);
	// ----------------------------------------
	// helpers
	// ----------------------------------------
	logic is_map;
	assign is_map = sfr_addr == cgc_pkg::ADDR_INTERNAL_OSC_MODE
		|| sfr_addr == cgc_pkg::ADDR_MAIN_CLOCK_SELECT
		|| sfr_addr == cgc_pkg::ADDR_HS_OSC_CONTROL
		|| sfr_addr == cgc_pkg::ADDR_CPU_DIVIDER_CONTROL
		|| sfr_addr == cgc_pkg::ADDR_HS_CLOCK_MODE_SELECT;

	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!arst_n);

	sequence stop_take_s;
		stop_exec && ce;
	endsequence
	sequence fast_off_s;
		!x1_osc_enable && !hi_osc_enable && !ext_clock_enable;
	endsequence

	// ----------------------------------------
	// assertions
	// ----------------------------------------
	stop_halt_a:
		assert property (stop_take_s |=> ##[0:1] fast_off_s)
		else $error("fast oscillators still on after stop");
	reset_start_a:
		assert property ($rose(arst_n) |-> ##[1:2] hi_osc_enable && !main_src_hs)
		else $error("cpu not on internal oscillator after reset");
	lo_keep_a:
		assert property ($past(lo_osc_enable) && !lo_osc_stoppable
			&& !$past(lo_osc_stoppable) |-> lo_osc_enable)
		else $error("low oscillator halted without permission");
	lo_feeds_a:
		assert property (wdt_clock_en == lo_osc_enable
			&& tmh1_lo_clock_en == lo_osc_enable)
		else $error("watchdog or timer clock not tied to low oscillator");
	main_prs_a:
		assert property (main_src_hs |-> prs_src_hs)
		else $error("main clock on high speed without peripheral clock");
	rise_hs_a:
		assert property ($rose(main_src_hs) |-> x1_osc_enable || ext_clock_enable)
		else $error("main clock moved to a stopped source");
	switch_gap_a:
		assert property ($changed(main_src_hs) || $changed(prs_src_hs)
			|-> !cpu_clock_en && !$past(cpu_clock_en))
		else $error("cpu clock enable active across a source switch");
	hit_mapped_a:
		assert property (ce && sfr_rd && is_map |=> sfr_hit)
		else $error("mapped read not acknowledged");
	idle_read_a:
		assert property (ce && !(sfr_rd && is_map) |=> !sfr_hit && sfr_rdata == 8'h00)
		else $error("read data or hit without a mapped read");
endmodule

bind cgc_clock_control cgc_clock_control_checker #(.SETTLE_CYC(SETTLE_CYC)) i_chk
(
	.clk(clk), .arst_n(arst_n), .ce(ce), .sfr_addr(sfr_addr),
	.sfr_wr(sfr_wr), .sfr_rd(sfr_rd), .sfr_wdata(sfr_wdata),
	.sfr_rdata(sfr_rdata), .sfr_hit(sfr_hit), .stop_exec(stop_exec),
	.stop_release(stop_release), .lo_osc_stoppable(lo_osc_stoppable),
	.hs_clock_ready(hs_clock_ready), .x1_osc_enable(x1_osc_enable),
	.ext_clock_enable(ext_clock_enable), .x1_pin_function(x1_pin_function),
	.ext_clock_input_sel(ext_clock_input_sel), .hi_osc_enable(hi_osc_enable),
	.lo_osc_enable(lo_osc_enable), .main_src_hs(main_src_hs),
	.prs_src_hs(prs_src_hs), .cpu_clock_en(cpu_clock_en),
	.prs_clock_en(prs_clock_en), .wdt_clock_en(wdt_clock_en),
	.tmh1_lo_clock_en(tmh1_lo_clock_en)
);
`default_nettype wire

// [test/test_clock_generator_control.sv]
// self-checking testbench of the clock generator control block
`timescale 1ns/1ps
`default_nettype none
module test_clock_generator_control;
	localparam logic [15:0] A_INT  = cgc_pkg::ADDR_INTERNAL_OSC_MODE;
	localparam logic [15:0] A_MAIN = cgc_pkg::ADDR_MAIN_CLOCK_SELECT;
	localparam logic [15:0] A_HSO  = cgc_pkg::ADDR_HS_OSC_CONTROL;
	localparam logic [15:0] A_DIV  = cgc_pkg::ADDR_CPU_DIVIDER_CONTROL;
	localparam logic [15:0] A_PIN  = cgc_pkg::ADDR_HS_CLOCK_MODE_SELECT;

	typedef struct packed {
		logic        wr;
		logic        stp;
		logic [15:0] a;
		logic [7:0]  d;
		logic [7:0]  q;
		logic        h;
	} cgc_row_t;

	logic        clk = 1'b0;
	logic        arst_n = 1'b0;
	logic [15:0] sfr_addr = 16'h0000;
	logic        sfr_wr = 1'b0;
	logic        sfr_rd = 1'b0;
	logic [7:0]  sfr_wdata = 8'h00;
	logic [7:0]  sfr_rdata;
	logic        sfr_hit;
	logic        stop_exec = 1'b0;
	logic        stop_release = 1'b0;
	logic        lo_osc_stoppable = 1'b0;
	logic        hs_clock_ready = 1'b0;
	logic        x1_en, ext_en, pin_fn, ext_sel, hi_en, lo_en;
	logic        main_hs, prs_hs, cpu_en, prs_en, wdt_en, tmh_en;
	logic        ce = 1'b1;
	int          errors = 0;
	int          total_checks = 0;
	int          n_cpu;
	int          n_prs;
	cgc_row_t    rows [7];

	always #20 clk = ~clk;

	cgc_clock_control #(.SETTLE_CYC(4)) i_dut
	(
		.clk(clk), .arst_n(arst_n), .ce(ce), .sfr_addr(sfr_addr),
		.sfr_wr(sfr_wr), .sfr_rd(sfr_rd), .sfr_wdata(sfr_wdata),
		.sfr_rdata(sfr_rdata), .sfr_hit(sfr_hit), .stop_exec(stop_exec),
		.stop_release(stop_release), .lo_osc_stoppable(lo_osc_stoppable),
		.hs_clock_ready(hs_clock_ready), .x1_osc_enable(x1_en),
		.ext_clock_enable(ext_en), .x1_pin_function(pin_fn),
		.ext_clock_input_sel(ext_sel), .hi_osc_enable(hi_en),
		.lo_osc_enable(lo_en), .main_src_hs(main_hs), .prs_src_hs(prs_hs),
		.cpu_clock_en(cpu_en), .prs_clock_en(prs_en),
		.wdt_clock_en(wdt_en), .tmh1_lo_clock_en(tmh_en)
	);

	// ----------------------------------------
	// tasks
	// ----------------------------------------
	task automatic give_verdict();
		if (errors == 0 && total_checks > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask

	task automatic chk_byte(input logic [7:0] got, input logic [7:0] exp);
		total_checks++;
		if (got !== exp)
		begin
			errors++;
			$display("wrong value at %0t: byte %h, want %h", $time, got, exp);
		end
	endtask

	task automatic chk_bit(input logic got, input logic exp);
		total_checks++;
		if (got !== exp)
		begin
			errors++;
			$display("wrong value at %0t: bit %b, want %b", $time, got, exp);
		end
	endtask

	// all bus tasks start and end at a falling edge
	task automatic wr_reg(input logic [15:0] a, input logic [7:0] d);
		sfr_addr = a;
		sfr_wdata = d;
		sfr_wr = 1'b1;
		@(negedge clk);
		sfr_wr = 1'b0;
	endtask

	task automatic rd_chk(input logic [15:0] a, input logic [7:0] e, input logic eh);
		sfr_addr = a;
		sfr_rd = 1'b1;
		@(negedge clk);
		sfr_rd = 1'b0;
		chk_byte(sfr_rdata, e);
		chk_bit(sfr_hit, eh);
		@(negedge clk);
	endtask

	task automatic wait_cyc(input int n);
		repeat (n) @(negedge clk);
	endtask

	// reset, then the first access lands before the settle count ends
	task automatic reset_checks();
		arst_n = 1'b0;
		repeat (2) @(negedge clk);
		arst_n = 1'b1;
		rd_chk(A_INT, 8'h00, 1'b1);
		chk_bit(hi_en, 1'b1);
		chk_bit(main_hs, 1'b0);
		chk_bit(lo_en, 1'b1);
		chk_bit(x1_en | ext_en, 1'b0);
		chk_bit(prs_en, 1'b1);
		chk_bit(wdt_en & tmh_en, 1'b1);
		rd_chk(A_MAIN, 8'h00, 1'b1);
		rd_chk(A_HSO, 8'h80, 1'b1);
		rd_chk(A_DIV, 8'h01, 1'b1);
		rd_chk(A_PIN, 8'h00, 1'b1);
		wait_cyc(10);
		rd_chk(A_INT, 8'h80, 1'b1);
	endtask

	// ----------------------------------------
	// main sequence
	// ----------------------------------------
	initial
	begin
		rows = '{
			'{1'b1, 1'b0, A_DIV, 8'h05, 8'h01, 1'b1},
			'{1'b1, 1'b0, A_DIV, 8'h04, 8'h04, 1'b1},
			'{1'b1, 1'b0, A_PIN, 8'hC0, 8'hC0, 1'b1},
			'{1'b1, 1'b0, A_INT, 8'h02, 8'h80, 1'b1},
			'{1'b1, 1'b1, A_INT, 8'h02, 8'h82, 1'b1},
			'{1'b1, 1'b1, A_INT, 8'h00, 8'h80, 1'b1},
			'{1'b0, 1'b1, 16'hFFA3, 8'h00, 8'h00, 1'b0}};
		@(negedge clk);
		reset_checks();
		foreach (rows[i])
		begin
			lo_osc_stoppable = rows[i].stp;
			if (rows[i].wr)
				wr_reg(rows[i].a, rows[i].d);
			rd_chk(rows[i].a, rows[i].q, rows[i].h);
			if (rows[i].a == A_INT)
			begin
				chk_bit(lo_en, ~rows[i].q[1]);
				chk_bit(wdt_en | tmh_en, ~rows[i].q[1]);
			end
		end
		// each divider code: count cpu and peripheral enables in 64 cycles
		for (int c = 0; c < 5; c++)
		begin
			wr_reg(A_DIV, 8'(c));
			wait_cyc(20);
			n_cpu = 0;
			n_prs = 0;
			repeat (64)
			begin
				@(negedge clk);
				if (cpu_en === 1'b1)
					n_cpu++;
				if (prs_en === 1'b1)
					n_prs++;
			end
			chk_byte(8'(n_cpu), 8'(64 >> c));
			chk_byte(8'(n_prs), 8'h40);
		end
		hs_clock_ready = 1'b1;
		wr_reg(A_HSO, 8'h00);
		wait_cyc(2);
		chk_bit(ext_en, 1'b1);
		chk_bit(x1_en, 1'b0);
		chk_bit(pin_fn & ext_sel, 1'b1);
		wr_reg(A_MAIN, 8'h04);
		wait_cyc(12);
		chk_bit(prs_hs, 1'b1);
		chk_bit(main_hs, 1'b0);
		wr_reg(A_MAIN, 8'h05);
		wait_cyc(12);
		rd_chk(A_MAIN, 8'h07, 1'b1);
		chk_bit(main_hs, 1'b1);
		wr_reg(A_MAIN, 8'h01);
		wait_cyc(12);
		rd_chk(A_MAIN, 8'h07, 1'b1);
		wr_reg(A_INT, 8'h01);
		wait_cyc(2);
		chk_bit(hi_en, 1'b0);
		rd_chk(A_INT, 8'h01, 1'b1);
		wr_reg(A_INT, 8'h00);
		wait_cyc(10);
		rd_chk(A_INT, 8'h80, 1'b1);
		wr_reg(A_MAIN, 8'h04);
		wait_cyc(12);
		rd_chk(A_MAIN, 8'h04, 1'b1);
		wr_reg(A_HSO, 8'h80);
		wait_cyc(2);
		chk_bit(ext_en, 1'b0);
		// stop halts the fast oscillators but not the low one
		stop_exec = 1'b1;
		@(negedge clk);
		stop_exec = 1'b0;
		wait_cyc(2);
		chk_bit(hi_en | x1_en | ext_en, 1'b0);
		chk_bit(lo_en, 1'b1);
		stop_release = 1'b1;
		@(negedge clk);
		stop_release = 1'b0;
		wait_cyc(4);
		chk_bit(hi_en, 1'b1);
		// a write with the clock enable low must leave no trace
		ce = 1'b0;
		wr_reg(A_DIV, 8'h02);
		ce = 1'b1;
		rd_chk(A_DIV, 8'h04, 1'b1);
		// a second reset frees the permit bit again
		reset_checks();
		wr_reg(A_MAIN, 8'h04);
		rd_chk(A_MAIN, 8'h04, 1'b1);
		// crystal mode: pins set while halted, then oscillator enabled
		wr_reg(A_PIN, 8'h40);
		wait_cyc(1);
		wr_reg(A_HSO, 8'h00);
		wait_cyc(2);
		chk_bit(x1_en & ~ext_en, 1'b1);
		give_verdict();
	end

	initial
	begin
		#200000;
		errors++;
		give_verdict();
	end
endmodule
`default_nettype wire

// [verilog/cgc_clock_control.sv]
// clock generator control: source selection, oscillator enables, cpu divider
`timescale 1ns/1ps
`default_nettype none

// Notes on behaviour
// RULE_01 - after reset cpu runs from internal oscillator
// RULE_02 - stop halts x1, internal osc, ext input
// RULE_03 - low osc runs; halt only if permitted
// RULE_04 - low osc never cpu; feeds watchdog, timer
// RULE_05 - software changes pin bits only while halted
// RULE_06 - software writes zero low bits; reset clears
// RULE_07 - divider codes 0..4 divide by powers two
// RULE_08 - peripheral clock never divided by cpu ratio
// RULE_09 - stable flag zero at reset, sets later
// RULE_10 - bit 0 stops internal high oscillator
// RULE_11 - bit 1 stops internal low oscillator
// RULE_12 - software halts internal osc only on hs
// RULE_13 - hs halt bit stops x1, reset one
// RULE_14 - software halts hs only on internal osc
// RULE_15 - never enable hs while pins are ports
// RULE_16 - software reinitialises peripherals after clock stop
// RULE_17 - permit bit chooses peripheral and main sources
// RULE_18 - status bit shows actual cpu source
// RULE_19 - permit bit changes once per reset
// RULE_20 - source switching glitch-free, status follows
module cgc_clock_control
#(
	parameter int SETTLE_CYC = cgc_pkg::HI_OSC_SETTLE_CYC
)
(
	input  wire logic        clk,
	input  wire logic        arst_n,
	input  wire logic        ce,
	input  wire logic [15:0] sfr_addr,
	input  wire logic        sfr_wr,
	input  wire logic        sfr_rd,
	input  wire logic [7:0]  sfr_wdata,
	output logic      [7:0]  sfr_rdata,
	output logic             sfr_hit,
	input  wire logic        stop_exec,
	input  wire logic        stop_release,
	input  wire logic        lo_osc_stoppable,
	input  wire logic        hs_clock_ready,
	output logic             x1_osc_enable,
	output logic             ext_clock_enable,
	output logic             x1_pin_function,
	output logic             ext_clock_input_sel,
	output logic             hi_osc_enable,
	output logic             lo_osc_enable,
	output logic             main_src_hs,
	output logic             prs_src_hs,
	output logic             cpu_clock_en,
	output logic             prs_clock_en,
	output logic             wdt_clock_en,
	output logic             tmh1_lo_clock_en
);
	// ------------------------------------------------------------
	// register state
	// ------------------------------------------------------------
	logic       hi_osc_halt;
	logic       lo_osc_halt;
	logic       hi_osc_stable_flag;
	logic       hs_source_permit;
	logic       permit_used;
	logic       main_source_pick;
	logic       hs_clock_halt;
	logic [2:0] cpu_div;
	logic       pin_fn;
	logic       ext_sel;
	logic       stopped;

	logic       next_hi_osc_halt;
	logic       next_lo_osc_halt;
	logic       next_hs_source_permit;
	logic       next_permit_used;
	logic       next_main_source_pick;
	logic       next_hs_clock_halt;
	logic [2:0] next_cpu_div;
	logic       next_pin_fn;
	logic       next_ext_sel;
	logic       next_stopped;
	logic [7:0] next_rdata;
	logic       next_hit;

	logic       hs_ready_s;
	logic       main_source_state;
	logic       wr_iom;
	logic       wr_mcs;
	logic       wr_hoc;
	logic       wr_div;
	logic       wr_hcm;

	cgc_sync3 u_hs_ready_sync
	(
		.clk    (clk),
		.arst_n (arst_n),
		.ce     (ce),
		.din    (hs_clock_ready),
		.dout   (hs_ready_s)
	);

	assign wr_iom = sfr_wr && sfr_addr == cgc_pkg::ADDR_INTERNAL_OSC_MODE;
	assign wr_mcs = sfr_wr && sfr_addr == cgc_pkg::ADDR_MAIN_CLOCK_SELECT;
	assign wr_hoc = sfr_wr && sfr_addr == cgc_pkg::ADDR_HS_OSC_CONTROL;
	assign wr_div = sfr_wr && sfr_addr == cgc_pkg::ADDR_CPU_DIVIDER_CONTROL;
	assign wr_hcm = sfr_wr && sfr_addr == cgc_pkg::ADDR_HS_CLOCK_MODE_SELECT;

	// ------------------------------------------------------------
	// register writes
	// ------------------------------------------------------------
	always_comb
	begin
		next_hi_osc_halt      = hi_osc_halt;
		next_lo_osc_halt      = lo_osc_halt;
		next_hs_source_permit = hs_source_permit;
		next_permit_used      = permit_used;
		next_main_source_pick = main_source_pick;
		next_hs_clock_halt    = hs_clock_halt;
		next_cpu_div          = cpu_div;
		next_pin_fn           = pin_fn;
		next_ext_sel          = ext_sel;
		next_stopped          = stopped;
		if (wr_iom)
		begin
			next_hi_osc_halt = sfr_wdata[cgc_pkg::HI_OSC_HALT_BIT]; // [RULE_10]
			// a locked low oscillator keeps its halt bit at zero
			next_lo_osc_halt = sfr_wdata[cgc_pkg::LO_OSC_HALT_BIT]
				&& lo_osc_stoppable; // [RULE_03] [RULE_11]
		end
		if (wr_mcs)
		begin
			next_main_source_pick = sfr_wdata[cgc_pkg::MAIN_SOURCE_PICK_BIT];
			if (!permit_used && sfr_wdata[cgc_pkg::HS_SOURCE_PERMIT_BIT]
				!= hs_source_permit)
			begin
				next_hs_source_permit =
					sfr_wdata[cgc_pkg::HS_SOURCE_PERMIT_BIT]; // [RULE_19]
				next_permit_used = 1'b1; // [RULE_19]
			end
		end
		if (wr_hoc)
			next_hs_clock_halt = sfr_wdata[cgc_pkg::HS_CLOCK_HALT_BIT]; // [RULE_13]
		if (wr_div && sfr_wdata[2:0] <= cgc_pkg::DIV_CODE_MAX)
			next_cpu_div = sfr_wdata[2:0]; // [RULE_07]
		if (wr_hcm)
		begin
			next_ext_sel = sfr_wdata[cgc_pkg::EXT_CLOCK_INPUT_SEL_BIT];
			next_pin_fn  = sfr_wdata[cgc_pkg::X1_PIN_FUNCTION_BIT];
		end
		if (stop_exec)
			next_stopped = 1'b1; // [RULE_02]
		else if (stop_release)
			next_stopped = 1'b0;
	end

	always_ff @(posedge clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			hi_osc_halt      <= cgc_pkg::RST_INTERNAL_OSC_MODE[0];
			lo_osc_halt      <= cgc_pkg::RST_INTERNAL_OSC_MODE[1];
			hs_source_permit <= cgc_pkg::RST_MAIN_CLOCK_SELECT[2];
			permit_used      <= 1'b0;
			main_source_pick <= cgc_pkg::RST_MAIN_CLOCK_SELECT[0];
			hs_clock_halt    <= cgc_pkg::RST_HS_OSC_CONTROL[7]; // [RULE_13]
			cpu_div          <= cgc_pkg::RST_CPU_DIVIDER_CONTROL[2:0]; // [RULE_07]
			pin_fn           <= cgc_pkg::RST_HS_CLOCK_MODE_SELECT[6]; // [RULE_06]
			ext_sel          <= cgc_pkg::RST_HS_CLOCK_MODE_SELECT[7]; // [RULE_06]
			stopped          <= 1'b0;
		end
		else if (ce)
		begin
			hi_osc_halt      <= next_hi_osc_halt;
			lo_osc_halt      <= next_lo_osc_halt;
			hs_source_permit <= next_hs_source_permit;
			permit_used      <= next_permit_used;
			main_source_pick <= next_main_source_pick;
			hs_clock_halt    <= next_hs_clock_halt;
			cpu_div          <= next_cpu_div;
			pin_fn           <= next_pin_fn;
			ext_sel          <= next_ext_sel;
			stopped          <= next_stopped;
		end
	end

	// ------------------------------------------------------------
	// internal oscillator settle counter
	// ------------------------------------------------------------
	logic [cgc_pkg::SETTLE_CNT_W-1:0] settle_cnt;
	logic [cgc_pkg::SETTLE_CNT_W-1:0] next_settle_cnt;
	logic                             next_stable;
	logic                             hi_run;

	assign hi_run = !hi_osc_halt && !stopped;

	always_comb
	begin
		next_settle_cnt = settle_cnt;
		next_stable     = hi_osc_stable_flag;
		if (!hi_run)
		begin
			next_settle_cnt = '0;
			next_stable     = 1'b0;
		end
		else if (settle_cnt
			== cgc_pkg::SETTLE_CNT_W'(SETTLE_CYC - 1))
			next_stable = 1'b1; // [RULE_09]
		else
			next_settle_cnt = settle_cnt + 1'b1;
	end

	always_ff @(posedge clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			settle_cnt         <= '0;
			hi_osc_stable_flag <= 1'b0; // [RULE_09]
		end
		else if (ce)
		begin
			settle_cnt         <= next_settle_cnt;
			hi_osc_stable_flag <= next_stable;
		end
	end

	// ------------------------------------------------------------
	// glitch-free source switch
	// ------------------------------------------------------------
	cgc_pkg::cgc_sw_state_t sw_state;
	cgc_pkg::cgc_sw_state_t next_sw_state;
	logic [1:0]             gap_cnt;
	logic [1:0]             next_gap_cnt;
	logic                   want_main_hs;
	logic                   want_prs_hs;
	logic                   next_main_src_hs;
	logic                   next_prs_src_hs;

	// permit at 0 forces both clocks onto the internal oscillator
	assign want_prs_hs  = hs_source_permit; // [RULE_17]
	assign want_main_hs = hs_source_permit && main_source_pick
		&& hs_ready_s && !hs_clock_halt; // [RULE_17]

	// both clocks are gated for a short gap so no runt pulse escapes
	always_comb
	begin
		next_sw_state    = sw_state;
		next_gap_cnt     = gap_cnt;
		next_main_src_hs = main_src_hs;
		next_prs_src_hs  = prs_src_hs;
		case (sw_state)
			cgc_pkg::CGC_SW_IDLE:
				if (want_main_hs != main_src_hs || want_prs_hs != prs_src_hs)
				begin
					next_sw_state = cgc_pkg::CGC_SW_GAP; // [RULE_20]
					next_gap_cnt  = cgc_pkg::SWITCH_GAP_CYC;
				end
			cgc_pkg::CGC_SW_GAP:
				if (gap_cnt == 2'h0)
				begin
					next_main_src_hs = want_main_hs; // [RULE_20]
					next_prs_src_hs  = want_prs_hs;
					next_sw_state    = cgc_pkg::CGC_SW_DONE;
				end
				else
					next_gap_cnt = gap_cnt - 2'h1;
			cgc_pkg::CGC_SW_DONE:
				next_sw_state = cgc_pkg::CGC_SW_IDLE;
			default:
				next_sw_state = cgc_pkg::CGC_SW_IDLE;
		endcase
	end

	always_ff @(posedge clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			sw_state    <= cgc_pkg::CGC_SW_IDLE;
			gap_cnt     <= 2'h0;
			main_src_hs <= 1'b0; // [RULE_01]
			prs_src_hs  <= 1'b0;
		end
		else if (ce)
		begin
			sw_state    <= next_sw_state;
			gap_cnt     <= next_gap_cnt;
			main_src_hs <= next_main_src_hs;
			prs_src_hs  <= next_prs_src_hs;
		end
	end

	// status reports the source actually in use
	assign main_source_state = main_src_hs; // [RULE_18]

	// ------------------------------------------------------------
	// cpu divider and clock enables
	// ------------------------------------------------------------
	logic div_tick;
	logic main_running;
	logic switching;
	logic next_cpu_en;
	logic next_prs_en;

	assign switching    = sw_state != cgc_pkg::CGC_SW_IDLE;
	assign main_running = !stopped && (main_src_hs
		? !hs_clock_halt : !hi_osc_halt);

	cgc_divider u_div
	(
		.clk    (clk),
		.arst_n (arst_n),
		.ce     (ce),
		.run    (main_running),
		.code   (cpu_div),
		.tick   (div_tick)
	);

	always_comb
	begin
		next_cpu_en = div_tick && !switching; // [RULE_07]
		// peripheral clock takes no part in the cpu divide ratio
		next_prs_en = !stopped && !switching
			&& (prs_src_hs ? !hs_clock_halt : !hi_osc_halt); // [RULE_08]
	end

	always_ff @(posedge clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			cpu_clock_en     <= 1'b0;
			prs_clock_en     <= 1'b0;
			wdt_clock_en     <= 1'b0;
			tmh1_lo_clock_en <= 1'b0;
			x1_osc_enable    <= 1'b0;
			ext_clock_enable <= 1'b0;
			hi_osc_enable    <= 1'b0;
			lo_osc_enable    <= 1'b0;
			x1_pin_function  <= 1'b0;
			ext_clock_input_sel <= 1'b0;
		end
		else if (ce)
		begin
			cpu_clock_en     <= next_cpu_en;
			prs_clock_en     <= next_prs_en;
			// the low oscillator serves only watchdog and timer h1
			wdt_clock_en     <= !lo_osc_halt; // [RULE_04]
			tmh1_lo_clock_en <= !lo_osc_halt; // [RULE_04]
			x1_osc_enable    <= !hs_clock_halt && !stopped
				&& pin_fn && !ext_sel; // [RULE_02] [RULE_13]
			ext_clock_enable <= !hs_clock_halt && !stopped
				&& pin_fn && ext_sel; // [RULE_02] [RULE_13]
			hi_osc_enable    <= hi_run; // [RULE_02] [RULE_01]
			lo_osc_enable    <= !lo_osc_halt; // [RULE_03]
			x1_pin_function  <= pin_fn;
			ext_clock_input_sel <= ext_sel;
		end
	end

	// ------------------------------------------------------------
	// register reads
	// ------------------------------------------------------------
	always_comb
	begin
		next_rdata = 8'h00;
		next_hit   = 1'b1;
		// an idle bus reads as zero, so no stale register value lingers
		case (sfr_rd ? sfr_addr : 16'h0000)
			cgc_pkg::ADDR_INTERNAL_OSC_MODE:
				next_rdata = {hi_osc_stable_flag, 5'h00,
					lo_osc_halt, hi_osc_halt}; // [RULE_09]
			cgc_pkg::ADDR_MAIN_CLOCK_SELECT:
				next_rdata = {5'h00, hs_source_permit,
					main_source_state, main_source_pick}; // [RULE_18]
			cgc_pkg::ADDR_HS_OSC_CONTROL:
				next_rdata = {hs_clock_halt, 7'h00};
			cgc_pkg::ADDR_CPU_DIVIDER_CONTROL:
				next_rdata = {5'h00, cpu_div};
			cgc_pkg::ADDR_HS_CLOCK_MODE_SELECT:
				next_rdata = {ext_sel, pin_fn, 6'h00};
			default:
				next_hit = 1'b0;
		endcase
	end

	always_ff @(posedge clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			sfr_rdata <= 8'h00;
			sfr_hit   <= 1'b0;
		end
		else if (ce)
		begin
			sfr_rdata <= next_rdata;
			sfr_hit   <= next_hit;
		end
	end
endmodule
`default_nettype wire

// [verilog/cgc_divider.sv]
// cpu clock-enable divider: main clock divided by 1, 2, 4, 8 or 16
`timescale 1ns/1ps
`default_nettype none
module cgc_divider
#(
	parameter int CNT_W = cgc_pkg::DIV_CNT_W
)
(
	input  wire logic       clk,
	input  wire logic       arst_n,
	input  wire logic       ce,
	input  wire logic       run,
	input  wire logic [2:0] code,
	output var  logic       tick
);
	logic [CNT_W-1:0] cnt;
	logic [CNT_W-1:0] next_cnt;
	logic [CNT_W-1:0] mask;
	logic             next_tick;

	always_comb
	begin
		mask = (CNT_W'(1) << code) - CNT_W'(1);
		next_cnt  = cnt;
		next_tick = 1'b0;
		if (run)
		begin
			if ((cnt & mask) == mask)
			begin
				next_cnt  = '0;
				next_tick = 1'b1;
			end
			else
				next_cnt = cnt + CNT_W'(1);
		end
	end

	always_ff @(posedge clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			cnt  <= '0;
			tick <= 1'b0;
		end
		else if (ce)
		begin
			cnt  <= next_cnt;
			tick <= next_tick;
		end
	end
endmodule
`default_nettype wire

// [verilog/cgc_sync3.sv]
// three-stage synchroniser with agreement filter for a pin-side level
`timescale 1ns/1ps
`default_nettype none
module cgc_sync3
(
	input  wire logic clk,
	input  wire logic arst_n,
	input  wire logic ce,
	input  wire logic din,
	output var  logic dout
);
	logic s1;
	logic s2;
	logic s3;
	logic next_dout;

	// only the second and third stages are compared; s1 feeds s2 alone
	always_comb
	begin
		next_dout = dout;
		if (s2 == s3)
			next_dout = s3;
	end

	always_ff @(posedge clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			s1   <= 1'b0;
			s2   <= 1'b0;
			s3   <= 1'b0;
			dout <= 1'b0;
		end
		else if (ce)
		begin
			s1   <= din;
			s2   <= s1;
			s3   <= s2;
			dout <= next_dout;
		end
	end
endmodule
`default_nettype wire
